// *** hw/cwd_pkg.sv ***
package cwd_pkg;
    localparam int WORD_W = 14;
    // Register byte offsets; the array holds the first word at 8007h
    localparam logic [15:0] OSC_WORD_ADDR = 16'h8007;
    localparam logic [11:0] OSC_WORD_OFF = 12'h000;
    localparam logic [11:0] SUP_WORD_OFF = 12'h004;
    localparam logic [11:0] WDT_WORD_OFF = 12'h008;
    localparam logic [11:0] STAT_OFF = 12'h00c;
    // Unimplemented positions read as one
    localparam logic [13:0] OSC_UNIMPL = 14'h1088;
    localparam logic [13:0] SUP_UNIMPL = 14'h0118;
    localparam logic [13:0] WDT_UNIMPL = 14'h0080;
    localparam logic [13:0] ERASED = 14'h3fff;
    // Oscillator word fields
    localparam int FAILSAFE_BIT = 13;
    localparam int CLKSW_BIT = 11;
    localparam int PUMP_BIT = 10;
    localparam int VBAT_BIT = 9;
    localparam int CLKOUT_BIT = 8;
    localparam int RESET_OSC_LSB = 4;
    localparam int EXT_MODE_LSB = 0;
    // Supervisor word fields
    localparam int DEBUG_BIT = 13;
    localparam int STACK_BIT = 12;
    localparam int PINMAP_BIT = 11;
    localparam int ZERO_CROSS_BIT = 10;
    localparam int BOD_LEVEL_BIT = 9;
    localparam int BOD_MODE_LSB = 6;
    localparam int LPBOR_BIT = 5;
    localparam int POWERUP_LSB = 1;
    localparam int RSTPIN_BIT = 0;
    // Watchdog word fields
    localparam int WCCS_LSB = 11;
    localparam int WCWS_LSB = 8;
    localparam int WMODE_LSB = 5;
    localparam int WCPS_LSB = 0;
    // Power-up timer times and counts at 10 MHz
    localparam int CLK_HZ = 10000000;
    localparam int PUP_LONG_MS = 64;
    localparam int PUP_MID_MS = 16;
    localparam int PUP_SHORT_MS = 1;
    localparam int PUP_LONG_CYC = PUP_LONG_MS * (CLK_HZ / 1000);
    localparam int PUP_MID_CYC = PUP_MID_MS * (CLK_HZ / 1000);
    localparam int PUP_SHORT_CYC = PUP_SHORT_MS * (CLK_HZ / 1000);
    localparam logic [4:0] WDT_SW_PERIOD = 5'h1f;
    localparam logic [4:0] WDT_MAX_PERIOD = 5'h12;
    localparam logic [4:0] WDT_PS_BASE = 5'h05;

    typedef enum logic [2:0] {
        CWD_OSC_HF32 = 3'b000,
        CWD_OSC_HF_PLL2 = 3'b001,
        CWD_OSC_EXT_PLL4 = 3'b010,
        CWD_OSC_RSVD = 3'b011,
        CWD_OSC_SECONDARY = 3'b100,
        CWD_OSC_SLOW_INT = 3'b101,
        CWD_OSC_FAST_LOW = 3'b110,
        CWD_OSC_EXT = 3'b111
    } cwd_osc_e;

    typedef enum logic [1:0] {
        CWD_EXT_OFF = 2'b00,
        CWD_EXT_LOW = 2'b01,
        CWD_EXT_MID = 2'b10,
        CWD_EXT_HIGH = 2'b11
    } cwd_ext_e;

    typedef enum logic [1:0] {
        CWD_LDR_IDLE = 2'b00,
        CWD_LDR_FETCH = 2'b01,
        CWD_LDR_DONE = 2'b10
    } cwd_ldr_e;

    typedef struct packed {
        logic failsafeMonitorEnable;
        logic clockSwitchPermit;
        logic displayPumpPermit;
        logic batteryBackupEnable;
        logic clockOutEnable;
        cwd_osc_e currentOscSelect;
        cwd_ext_e externalOscMode;
    } cwd_osc_s;

    typedef struct packed {
        logic debuggerEnable;
        logic stackFaultResetEnable;
        logic pinMapOneshotLock;
        logic zeroCrossForcedOn;
        logic brownoutLowLevel;
        logic [1:0] brownoutMode;
        logic ultralowBrownoutEnable;
        logic powerupTimerEnable;
        logic [19:0] powerupTimerCycles;
        logic resetPinIsReset;
        logic lowVoltageProgEnable;
        logic codeProtectEnable;
    } cwd_sup_s;

    typedef struct packed {
        logic [1:0] watchdogClockSel;
        logic watchdogClockSw;
        logic [3:0] watchdogWindowEighths;
        logic watchdogWindowSw;
        logic watchdogKeyRequired;
        logic [1:0] watchdogMode;
        logic [4:0] watchdogDividerLog2;
        logic watchdogPeriodSw;
    } cwd_wdt_s;
endpackage

// *** hw/cwd_config_word_decoder.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Words start at 8007h; decoded settings apply before core release.
// - Low-voltage programming bit 1 forces reset pin, ignores pin enable.
// - Code-protect bit 0 protects program memory; 1 leaves it open.
// - Oscillator bit 13 set enables fail-safe clock monitor timer.
// - Clock-switch bit 0 blocks software writes to next oscillator/divider.
// - Pump bit 0 forces display charge pump off; 1 permits it.
// - Battery pin bit 1 makes pin GPIO; 0 enables battery backup.
// - Clock-out bit 0 drives Fosc/4 only in external clock or off modes.
// - Reset oscillator field loads current oscillator selector at reset.
// - External mode 111/110/101 are clock ranges; lower codes disable.
// - Unimplemented configuration bits read back as one.
// - Stack fault reset bit 1 resets on overflow or underflow.
// - One-way lock bit 1 allows one pin-map unlock/lock cycle.
// - Zero-cross bit 0 forces detector on, ignoring software enable.
// - Brown-out level bit 1 selects lower trip level, 0 higher.
// - Brown-out field: always, awake only, software, or disabled.
// - Low-power brown-out bit 0 enables ultra-low-power detector.
// - Power-up timer field: off, 64 ms, 16 ms, 1 ms.
// - Reset pin is reset in low-voltage mode, else follows its enable.
// - Debugger bit 0 enables background debugger; tools keep it 1.
// - Watchdog clock: 000 medium osc, 001 slow osc, 111 software.
// - Window opening eighths by field; 111 gives software and no key.
// - Watchdog mode: off, software, awake only, always on.
// - Watchdog divider two to five plus code; 11111 software control.
module cwd_config_word_decoder (
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Nonvolatile array read port
    output logic [15:0] nvmAddr,
    output logic nvmRead,
    input wire logic [13:0] nvmData,
    input wire logic nvmValid,
    input wire logic lowVoltageProgEnable,
    input wire logic codeProtectN,
    // Live inputs that decoded settings gate
    input wire logic sleepActive,
    input wire logic brownoutSwEnable,
    input wire logic zeroCrossSwEnable,
    input wire logic pumpRequest,
    input wire logic stackFault,
    input wire logic clkSwWriteReq,
    input wire logic pinMapUnlockReq,
    input wire logic pinMapLockReq,
    input wire logic fosc4,
    output logic configReady,
    output cwd_pkg::cwd_osc_s oscCfg,
    output cwd_pkg::cwd_sup_s supCfg,
    output cwd_pkg::cwd_wdt_s wdtCfg,
    output logic clkSwWriteGrant,
    output logic displayPumpOn,
    output logic brownoutActive,
    output logic zeroCrossActive,
    output logic stackResetReq,
    output logic pinMapLocked,
    output logic clockOutPin,
    output logic clockOutPinOe,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import cwd_pkg::*;

    cwd_ldr_e ldrState_q;
    logic [1:0] wordIdx_q;
    logic [13:0] oscWord_q, supWord_q, wdtWord_q;
    logic lowVolt_q, protectN_q;
    logic mapUsed_q;

    // Loader fetches the three words in address order after reset
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ldrState_q <= CWD_LDR_IDLE;
            wordIdx_q <= 2'h0;
            nvmRead <= 1'b0;
            nvmAddr <= 16'h0000;
            configReady <= 1'b0;
        end else begin
            case (ldrState_q)
                CWD_LDR_IDLE: begin
                    nvmAddr <= OSC_WORD_ADDR;
                    nvmRead <= 1'b1;
                    ldrState_q <= CWD_LDR_FETCH;
                end
                CWD_LDR_FETCH: begin
                    if (nvmValid) begin
                        if (wordIdx_q == 2'h2) begin
                            nvmRead <= 1'b0;
                            ldrState_q <= CWD_LDR_DONE;
                        end else begin
                            nvmAddr <= nvmAddr + 16'h0001;
                        end
                        wordIdx_q <= wordIdx_q + 2'h1;
                    end
                end
                CWD_LDR_DONE: configReady <= 1'b1;
                default: ldrState_q <= CWD_LDR_IDLE;
            endcase
        end
    end

    // Words written once per reset, then frozen
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oscWord_q <= ERASED;
            supWord_q <= ERASED;
            wdtWord_q <= ERASED;
            lowVolt_q <= 1'b1;
            protectN_q <= 1'b1;
        end else if (ldrState_q == CWD_LDR_FETCH && nvmValid) begin
            case (wordIdx_q)
                2'h0: oscWord_q <= nvmData | OSC_UNIMPL;
                2'h1: supWord_q <= nvmData | SUP_UNIMPL;
                default: begin
                    wdtWord_q <= nvmData | WDT_UNIMPL;
                    lowVolt_q <= lowVoltageProgEnable;
                    protectN_q <= codeProtectN;
                end
            endcase
        end
    end

    function automatic logic [19:0] powerupCycles(input logic [1:0] code);
        case (code)
            2'b10: powerupCycles = 20'(PUP_LONG_CYC);
            2'b01: powerupCycles = 20'(PUP_MID_CYC);
            2'b00: powerupCycles = 20'(PUP_SHORT_CYC);
            default: powerupCycles = 20'h00000;
        endcase
    endfunction

    function automatic logic [3:0] windowEighths(input logic [2:0] code);
        if (code >= 3'b110) begin
            windowEighths = 4'h8;
        end else begin
            windowEighths = {1'b0, code} + 4'h1;
        end
    endfunction

    cwd_osc_s oscDec;
    cwd_sup_s supDec;
    cwd_wdt_s wdtDec;
    logic [2:0] extCode, ccsCode, cwsCode;
    logic [4:0] cpsCode;

    always_comb begin
        extCode = oscWord_q[EXT_MODE_LSB +: 3];
        ccsCode = wdtWord_q[WCCS_LSB +: 3];
        cwsCode = wdtWord_q[WCWS_LSB +: 3];
        cpsCode = wdtWord_q[WCPS_LSB +: 5];
        oscDec.failsafeMonitorEnable = oscWord_q[FAILSAFE_BIT];
        oscDec.clockSwitchPermit = oscWord_q[CLKSW_BIT];
        oscDec.displayPumpPermit = oscWord_q[PUMP_BIT];
        oscDec.batteryBackupEnable = ~oscWord_q[VBAT_BIT];
        // Any disabled code means not enabled
        case (extCode)
            3'b111: oscDec.externalOscMode = CWD_EXT_HIGH;
            3'b110: oscDec.externalOscMode = CWD_EXT_MID;
            3'b101: oscDec.externalOscMode = CWD_EXT_LOW;
            default: oscDec.externalOscMode = CWD_EXT_OFF;
        endcase
        // All external modes are clocks or off, so the bit always applies
        oscDec.clockOutEnable = ~oscWord_q[CLKOUT_BIT];
        oscDec.currentOscSelect =
            cwd_osc_e'(oscWord_q[RESET_OSC_LSB +: 3]);
        supDec.debuggerEnable = ~supWord_q[DEBUG_BIT];
        supDec.stackFaultResetEnable = supWord_q[STACK_BIT];
        supDec.pinMapOneshotLock = supWord_q[PINMAP_BIT];
        supDec.zeroCrossForcedOn = ~supWord_q[ZERO_CROSS_BIT];
        supDec.brownoutLowLevel = supWord_q[BOD_LEVEL_BIT];
        supDec.brownoutMode = supWord_q[BOD_MODE_LSB +: 2];
        supDec.ultralowBrownoutEnable = ~supWord_q[LPBOR_BIT];
        supDec.powerupTimerEnable =
            (supWord_q[POWERUP_LSB +: 2] != 2'b11);
        supDec.powerupTimerCycles =
            powerupCycles(supWord_q[POWERUP_LSB +: 2]);
        supDec.resetPinIsReset =
            lowVolt_q | supWord_q[RSTPIN_BIT];
        supDec.lowVoltageProgEnable = lowVolt_q;
        supDec.codeProtectEnable = ~protectN_q;
        // Reserved clock codes fall back to the slow oscillator
        wdtDec.watchdogClockSel =
            (ccsCode == 3'b000) ? 2'b00 : 2'b01;
        wdtDec.watchdogClockSw = (ccsCode == 3'b111);
        wdtDec.watchdogWindowEighths = windowEighths(cwsCode);
        wdtDec.watchdogWindowSw = (cwsCode == 3'b111);
        wdtDec.watchdogKeyRequired = (cwsCode != 3'b111);
        wdtDec.watchdogMode = wdtWord_q[WMODE_LSB +: 2];
        wdtDec.watchdogPeriodSw = (cpsCode == WDT_SW_PERIOD);
        if (cpsCode <= WDT_MAX_PERIOD) begin
            wdtDec.watchdogDividerLog2 = cpsCode + WDT_PS_BASE;
        end else begin
            // Unlisted codes and the software default start at 1:32
            wdtDec.watchdogDividerLog2 = WDT_PS_BASE;
        end
    end

    // Decoded outputs registered once loading ends
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oscCfg <= '0;
            supCfg <= '0;
            wdtCfg <= '0;
        end else if (ldrState_q == CWD_LDR_DONE && !configReady) begin
            oscCfg <= oscDec;
            supCfg <= supDec;
            wdtCfg <= wdtDec;
        end
    end

    logic bodOn;
    always_comb begin
        case (supCfg.brownoutMode)
            2'b11: bodOn = 1'b1;
            2'b10: bodOn = ~sleepActive;
            2'b01: bodOn = brownoutSwEnable;
            default: bodOn = 1'b0;
        endcase
    end

    // Runtime gating by decoded settings
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkSwWriteGrant <= 1'b0;
            displayPumpOn <= 1'b0;
            brownoutActive <= 1'b0;
            zeroCrossActive <= 1'b0;
            stackResetReq <= 1'b0;
            clockOutPin <= 1'b0;
            clockOutPinOe <= 1'b0;
        end else begin
            clkSwWriteGrant <= configReady & clkSwWriteReq &
                oscCfg.clockSwitchPermit;
            displayPumpOn <= configReady & pumpRequest &
                oscCfg.displayPumpPermit;
            brownoutActive <= configReady & bodOn;
            zeroCrossActive <= configReady &
                (supCfg.zeroCrossForcedOn | zeroCrossSwEnable);
            stackResetReq <= configReady & stackFault &
                supCfg.stackFaultResetEnable;
            clockOutPin <= fosc4 & oscCfg.clockOutEnable;
            clockOutPinOe <= configReady & oscCfg.clockOutEnable;
        end
    end

    // Pin-map lock: one unlock allowed when oneshot set
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMapLocked <= 1'b0;
            mapUsed_q <= 1'b0;
        end else if (configReady) begin
            if (pinMapLockReq) begin
                pinMapLocked <= 1'b1;
                if (supCfg.pinMapOneshotLock && mapUsed_q) begin
                    mapUsed_q <= 1'b1;
                end
            end else if (pinMapUnlockReq) begin
                if (!(supCfg.pinMapOneshotLock && mapUsed_q)) begin
                    pinMapLocked <= 1'b0;
                    mapUsed_q <= 1'b1;
                end
            end
        end
    end

    // APB: read-only, zero wait, writes and unmapped addresses error
    logic accessPhase;
    assign accessPhase = psel & ~penable;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= accessPhase;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (accessPhase) begin
                if (pwrite) begin
                    pslverr <= 1'b1;
                end else begin
                    case (paddr)
                        OSC_WORD_OFF: prdata <= {18'h0, oscWord_q};
                        SUP_WORD_OFF: prdata <= {18'h0, supWord_q};
                        WDT_WORD_OFF: prdata <= {18'h0, wdtWord_q};
                        STAT_OFF: prdata <= {30'h0, pinMapLocked, configReady};
                        default: pslverr <= 1'b1;
                    endcase
                end
            end
        end
    end
endmodule

// *** sim/cwd_config_word_decoder_chk.sv ***
`timescale 1ns/1ps
module cwd_decoder_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic configReady,
    input wire cwd_pkg::cwd_osc_s oscCfg,
    input wire cwd_pkg::cwd_sup_s supCfg,
    input wire cwd_pkg::cwd_wdt_s wdtCfg,
    input wire logic sleepActive,
    input wire logic brownoutSwEnable,
    input wire logic zeroCrossSwEnable,
    input wire logic pumpRequest,
    input wire logic stackFault,
    input wire logic clkSwWriteReq,
    input wire logic fosc4,
    input wire logic clkSwWriteGrant,
    input wire logic displayPumpOn,
    input wire logic brownoutActive,
    input wire logic zeroCrossActive,
    input wire logic stackResetReq,
    input wire logic clockOutPin,
    input wire logic clockOutPinOe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr
);
    import cwd_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Gated outputs lag their inputs by one cycle, so both cycles need ready
    sequence s_on;
        configReady && $past(configReady);
    endsequence
    a_idle_quiet: assert property (
        !configReady |-> !(displayPumpOn || clkSwWriteGrant || brownoutActive
        || zeroCrossActive || stackResetReq || clockOutPinOe))
        else $error("gated output active before load");
    a_ready_hold: assert property (
        configReady |=> configReady && $stable(oscCfg) && $stable(supCfg)
        && $stable(wdtCfg)) else $error("loaded settings changed");
    a_pump_gate: assert property (s_on |-> displayPumpOn ==
        ($past(pumpRequest) && oscCfg.displayPumpPermit))
        else $error("pump output wrong");
    a_switch_gate: assert property (s_on |-> clkSwWriteGrant ==
        ($past(clkSwWriteReq) && oscCfg.clockSwitchPermit))
        else $error("clock switch grant wrong");
    a_stack_gate: assert property (s_on |-> stackResetReq ==
        ($past(stackFault) && supCfg.stackFaultResetEnable))
        else $error("stack reset request wrong");
    a_zero_cross: assert property (s_on |-> zeroCrossActive ==
        (supCfg.zeroCrossForcedOn || $past(zeroCrossSwEnable)))
        else $error("zero cross enable wrong");
    a_brownout_mode: assert property (s_on |-> brownoutActive ==
        (supCfg.brownoutMode == 2'h3 ||
        (supCfg.brownoutMode == 2'h2 && !$past(sleepActive)) ||
        (supCfg.brownoutMode == 2'h1 && $past(brownoutSwEnable))))
        else $error("brownout enable wrong");
    a_clock_out: assert property (s_on |->
        clockOutPinOe == oscCfg.clockOutEnable &&
        (!clockOutPinOe || clockOutPin == $past(fosc4)))
        else $error("clock out pin wrong");
    a_write_refused: assert property (
        psel && penable && pwrite && pready |-> pslverr)
        else $error("register write accepted");
    c_loaded: cover property ($rose(configReady));
    c_pump_clkout: cover property (displayPumpOn && clockOutPinOe);
    c_refused: cover property (pready && pslverr);
endmodule

bind cwd_config_word_decoder cwd_decoder_chk u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .configReady(configReady),
    .oscCfg(oscCfg), .supCfg(supCfg), .wdtCfg(wdtCfg),
    .sleepActive(sleepActive), .brownoutSwEnable(brownoutSwEnable),
    .zeroCrossSwEnable(zeroCrossSwEnable), .pumpRequest(pumpRequest),
    .stackFault(stackFault), .clkSwWriteReq(clkSwWriteReq), .fosc4(fosc4),
    .clkSwWriteGrant(clkSwWriteGrant), .displayPumpOn(displayPumpOn),
    .brownoutActive(brownoutActive), .zeroCrossActive(zeroCrossActive),
    .stackResetReq(stackResetReq), .clockOutPin(clockOutPin),
    .clockOutPinOe(clockOutPinOe), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr)
);

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import cwd_pkg::*;
    typedef struct packed {
        logic [13:0] osc;
        logic [13:0] sup;
        logic [13:0] wdt;
        logic lowVolt;
        logic protN;
    } cwd_row_s;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic nvmValid = 1'b0;
    logic [13:0] nvmData = 14'h0;
    logic lowVoltageProgEnable = 1'b0;
    logic codeProtectN = 1'b1;
    logic [6:0] live = 7'h0;
    logic pinMapUnlockReq = 1'b0;
    logic pinMapLockReq = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] nvmAddr;
    logic [31:0] prdata;
    logic nvmRead, configReady, pinMapLocked, pready, pslverr;
    cwd_osc_s oscCfg;
    cwd_sup_s supCfg;
    cwd_wdt_s wdtCfg;
    int n_errors = 0;
    int checks = 0;
    int n;
    logic [11:0] offs [3] = '{OSC_WORD_OFF, SUP_WORD_OFF, WDT_WORD_OFF};
    logic [13:0] unimp [3] = '{OSC_UNIMPL, SUP_UNIMPL, WDT_UNIMPL};
    // Words, then the two straps; unused bits are programmed in some rows
    cwd_row_s rows [8] = '{
        '{14'h2507, 14'h0000, 14'h0000, 1'b1, 1'b0},
        '{14'h0a16, 14'h3fff, 14'h0932, 1'b0, 1'b1},
        '{14'h2f25, 14'h1243, 14'h3a53, 1'b0, 1'b0},
        '{14'h0034, 14'h2ca4, 14'h137f, 1'b1, 1'b1},
        '{14'h2940, 14'h0118, 14'h3485, 1'b0, 1'b1},
        '{14'h0653, 14'h2ca4, 14'h0d2a, 1'b1, 1'b0},
        '{14'h10e9, 14'h1243, 14'h0641, 1'b0, 1'b1},
        '{14'h3fff, 14'h3fff, 14'h3fff, 1'b1, 1'b1}
    };

    cwd_config_word_decoder DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .nvmAddr(nvmAddr),
        .nvmRead(nvmRead), .nvmData(nvmData), .nvmValid(nvmValid),
        .lowVoltageProgEnable(lowVoltageProgEnable),
        .codeProtectN(codeProtectN), .sleepActive(live[6]),
        .brownoutSwEnable(live[5]), .zeroCrossSwEnable(live[4]),
        .pumpRequest(live[3]), .stackFault(live[2]),
        .clkSwWriteReq(live[1]), .fosc4(live[0]),
        .pinMapUnlockReq(pinMapUnlockReq), .pinMapLockReq(pinMapLockReq),
        .configReady(configReady), .oscCfg(oscCfg), .supCfg(supCfg),
        .wdtCfg(wdtCfg), .clkSwWriteGrant(), .displayPumpOn(),
        .brownoutActive(), .zeroCrossActive(), .stackResetReq(),
        .pinMapLocked(pinMapLocked), .clockOutPin(), .clockOutPinOe(),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr)
    );

    always #50 ref_clk = ~ref_clk;

    function automatic cwd_osc_s exp_osc(input logic [13:0] w);
        return '{w[13], w[11], w[10],
            !w[9], !w[8], cwd_osc_e'(w[6:4]),
            cwd_ext_e'(w[2] ? w[1:0] : 2'h0)};
    endfunction

    function automatic cwd_sup_s exp_sup(input logic [13:0] w,
                                         input logic lv, input logic cn);
        logic [19:0] c;
        c = w[1] ? (w[2] ? 20'h0 : 20'(PUP_MID_CYC)) :
            (w[2] ? 20'(PUP_LONG_CYC) : 20'(PUP_SHORT_CYC));
        return '{!w[13], w[12], w[11], !w[10],
            w[9], w[7:6], !w[5],
            w[2:1] != 2'h3, c, lv | w[0], lv, !cn};
    endfunction

    function automatic cwd_wdt_s exp_wdt(input logic [13:0] w);
        logic [2:0] s;
        logic [2:0] cw;
        logic [4:0] p;
        s = w[13:11];
        cw = w[10:8];
        p = w[4:0];
        return '{(s == 3'h0) ? 2'h0 : 2'h1, s == 3'h7,
            (cw > 3'h5) ? 4'h8 : {1'b0, cw} + 4'h1,
            cw == 3'h7, cw != 3'h7, w[6:5],
            (p > 5'h12) ? 5'h5 : p + 5'h5, p == 5'h1f};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("ready in reset", 32'h0, 32'(configReady));
        chk("osc in reset", 32'h0, 32'(oscCfg));
        sys_rst <= 1'b0;
    endtask

    task automatic load(input cwd_row_s r);
        logic [13:0] w [3];
        w = '{r.osc, r.sup, r.wdt};
        lowVoltageProgEnable <= r.lowVolt;
        codeProtectN <= r.protN;
        for (int i = 0; i < 3; i++) begin
            @(negedge ref_clk);
            for (n = 0; n < 8 && nvmRead !== 1'b1; n++) @(negedge ref_clk);
            chk("nvm addr", 32'(OSC_WORD_ADDR + 16'(i)),
                32'(nvmAddr));
            @(posedge ref_clk);
            nvmData <= w[i];
            nvmValid <= 1'b1;
            @(posedge ref_clk);
            nvmValid <= 1'b0;
            // Released array lines show the inverted word, not the last word
            nvmData <= ~w[i];
        end
        for (n = 0; n < 16 && configReady !== 1'b1; n++) @(negedge ref_clk);
        chk("ready", 32'h1, 32'(configReady));
        chk("nvm read", 32'h0, 32'(nvmRead));
    endtask

    // ci: setup follows the previous access at once; ko: keep the bus held
    task automatic apb(input bit ci, input bit ko, input logic wr,
                       input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        if (!ci) @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Slave outputs update by non-blocking assignment, so a read just
        // after the edge sees the value sampled at that edge
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk("apb answer", 32'h1, 32'(pready));
        d = prdata;
        e = pslverr;
        if (!ko) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    initial begin
        cwd_row_s r;
        cwd_wdt_s ew, gw;
        logic [13:0] words [3];
        logic [31:0] d;
        logic e;
        foreach (rows[i]) begin
            r = rows[i];
            do_reset();
            load(r);
            chk("osc cfg", 32'(exp_osc(r.osc)), 32'(oscCfg));
            chk("sup cfg", 32'(exp_sup(r.sup, r.lowVolt, r.protN)),
                32'(supCfg));
            ew = exp_wdt(r.wdt);
            gw = wdtCfg;
            // The selector value is free when software owns the clock choice
            gw.watchdogClockSel = ew.watchdogClockSw ? ew.watchdogClockSel :
                gw.watchdogClockSel;
            chk("wdt cfg", 32'(ew), 32'(gw));
            words = '{r.osc, r.sup, r.wdt};
            for (int k = 0; k < 3; k++) begin
                apb(1'b0, 1'b0, 1'b0, offs[k], 32'hffff_ffff, d, e);
                chk("word", {18'h0, words[k] | unimp[k]}, d);
                chk("word err", 32'h0, 32'(e));
            end
            apb(1'b0, 1'b0, 1'b0, STAT_OFF, 32'h0, d, e);
            chk("status ready", 32'h1, d & 32'h1);
            for (int k = 0; k < 4; k++) begin
                @(posedge ref_clk);
                pinMapLockReq <= !k[0];
                pinMapUnlockReq <= k[0];
                @(posedge ref_clk);
                pinMapLockReq <= 1'b0;
                pinMapUnlockReq <= 1'b0;
                repeat (2) @(negedge ref_clk);
                chk("pin lock", 32'((k == 3 && r.sup[11]) || !k[0]),
                    32'(pinMapLocked));
            end
            for (int k = 0; k < 128; k++) begin
                @(posedge ref_clk);
                live <= 7'(k);
            end
        end
        apb(1'b0, 1'b1, 1'b1, OSC_WORD_OFF, 32'h0, d, e);
        chk("write refused", 32'h1, 32'(e));
        apb(1'b1, 1'b1, 1'b0, OSC_WORD_OFF, 32'h0, d, e);
        chk("word after write", {18'h0, rows[7].osc | OSC_UNIMPL}, d);
        apb(1'b1, 1'b0, 1'b0, 12'h010, 32'hffff_ffff, d, e);
        chk("unmapped data", 32'h0, d);
        chk("unmapped err", 32'h1, 32'(e));
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        wrap_up();
    end
endmodule
